// ### bridge_hdr_defs.svh
/*
  Offsets, field positions, reset values and response codes for the
  bridge header register bank (header type through I/O window).
  Assumes: included by bare name from the design, checker and testbench files.
*/
`ifndef BRIDGE_HDR_DEFS_SVH
`define BRIDGE_HDR_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices as printed; byte address is four times the index
// ----------------------------------------------------------------------
`define IDX_HEADER_LAYOUT_CODE        12'h00E
`define IDX_SELF_TEST_CONTROL         12'h00F
`define IDX_UNUSED_WINDOW_ZERO        12'h010
`define IDX_UNUSED_WINDOW_ONE         12'h014
`define IDX_UPSTREAM_SEGMENT_NUMBER   12'h018
`define IDX_DOWNSTREAM_SEGMENT_NUMBER 12'h019
`define IDX_HIGHEST_SEGMENT_BEHIND    12'h01A
`define IDX_DOWNSTREAM_LATENCY_COUNT  12'h01B
`define IDX_IO_WINDOW_LOWER           12'h01C
`define IDX_IO_WINDOW_UPPER           12'h01D
`define IDX_HEADER_LOCK_CONTROL       12'h040

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define IO_WIDTH_BIT                  0
`define IO_ADDR_MSB                   7
`define IO_ADDR_LSB                   4
`define LOCK_BIT                      0

// ----------------------------------------------------------------------
// Constant and reset values
// ----------------------------------------------------------------------
`define HEADER_LAYOUT_VALUE           8'h01
`define SELF_TEST_VALUE               8'h00
`define UNUSED_WINDOW_VALUE           32'h0000_0000
`define LATENCY_COUNT_VALUE           8'h00
`define SEGMENT_RESET                 8'h00
`define IO_WIDTH_RESET                1'h1
`define IO_BASE_RESET                 4'hF
`define IO_LIMIT_RESET                4'h0
`define LOCK_RESET                    1'h0
`define IO_LOW_FILL                   12'h000
`define IO_HIGH_FILL                  12'hFFF

// ----------------------------------------------------------------------
// AXI4-Lite response codes
// ----------------------------------------------------------------------
`define RESP_OKAY                     2'h0
`define RESP_SLVERR                   2'h2

`endif

// ### bridge_hdr_pkg.sv
/*
  Types shared by the bridge header register bank and its I/O window
  decoder: channel states and carrier structs.
  Assumes: codes and widths are fixed here; bridge_hdr_defs.svh is not included.
*/
package bridge_hdr_pkg;

  // --------------------------------------------------------------------
  // Channel states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_IDLE      = 2'b00,  // Nothing held
    WR_HAVE_ADDR = 2'b01,  // Address taken, waiting for data
    WR_HAVE_DATA = 2'b10,  // Data taken, waiting for address
    WR_RESP      = 2'b11   // Response offered
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,        // Ready for an address
    RD_RESP = 1'b1         // Read data offered
  } rd_state_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       wide;      // 1: wide_io_addressing, 0: narrow_io_addressing
    logic [3:0] base;      // Address bits 15:12 of the window bottom
    logic [3:0] limit;     // Address bits 15:12 of the window top
  } io_window_s;

  typedef struct packed {
    logic        valid;    // Request present this cycle
    logic [31:0] addr;     // I/O address seen on the primary side
  } io_req_s;

endpackage : bridge_hdr_pkg

// ### bridge_hdr_regs.sv
/*
  Bridge configuration header bank, header type through I/O limit,
  reached over an AXI4-Lite slave, plus the I/O forwarding decision.
  Assumes: one clock, synchronous active-high reset, a well-behaved
  AXI4-Lite master with at most one read and one write outstanding.
*/
// The implementer's own choice: the AXI4-Lite interface to the registers.
// Overview of operation
// - Header type reads fixed 0x01, writes ignored.
// - Self-test byte reads zero, writes ignored.
// - Both base address registers read zero.
// - Upstream segment number is read/write, resets zero.
// - Downstream segment number is read/write, resets zero.
// - Highest segment behind is read/write, resets zero.
// - Downstream latency count reads zero always.
// - Width capability bit lockable, resets to wide.
// - Upper register bit 0 mirrors width bit.
// - Window base bits 7:4 read/write, reset ones.
// - Window limit bits 7:4 read/write, reset zero.
// - Bits 3:1 of both read zero.
`timescale 1ns/1ps
`include "bridge_hdr_defs.svh"

module bridge_hdr_regs (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // AXI4-Lite write address channel
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data channel
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response channel
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address channel
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data channel
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Upper address halves for wide I/O addressing
  input  wire logic [15:0]             io_upper_base,
  input  wire logic [15:0]             io_upper_limit,
  // Primary-side I/O request and forwarding verdict
  input  wire bridge_hdr_pkg::io_req_s io_req,
  output logic                         io_judged_q,
  output logic                         io_forward_q,
  // Programmed window, for the forwarding datapath
  output bridge_hdr_pkg::io_window_s   io_window_q
);
  import bridge_hdr_pkg::*;

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------

  // Byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[9:0], 2'b00};
  endfunction : byte_addr

  // Whether a byte address names a register of this bank
  function automatic logic addr_known(input logic [11:0] a);
    if (a == byte_addr(`IDX_HEADER_LAYOUT_CODE)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_SELF_TEST_CONTROL)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_UNUSED_WINDOW_ZERO)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_UNUSED_WINDOW_ONE)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_UPSTREAM_SEGMENT_NUMBER)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_DOWNSTREAM_SEGMENT_NUMBER)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_HIGHEST_SEGMENT_BEHIND)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_DOWNSTREAM_LATENCY_COUNT)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_IO_WINDOW_LOWER)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_IO_WINDOW_UPPER)) begin
      addr_known = 1'b1;
    end else if (a == byte_addr(`IDX_HEADER_LOCK_CONTROL)) begin
      addr_known = 1'b1;
    end else begin
      addr_known = 1'b0;
    end
  endfunction : addr_known

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  wr_state_e   wr_state_q, wr_state_d;     // Write channel progress
  rd_state_e   rd_state_q, rd_state_d;     // Read channel progress
  logic [11:0] awaddr_q, awaddr_d;         // Held write address
  logic [31:0] wdata_q, wdata_d;           // Held write data
  logic [3:0]  wstrb_q, wstrb_d;           // Held write strobes
  logic [1:0]  bresp_q, bresp_d;           // Write response code
  logic [31:0] rdata_q, rdata_d;           // Read data word
  logic [1:0]  rresp_q, rresp_d;           // Read response code
  logic [7:0]  up_seg_q, up_seg_d;         // upstream_segment_number
  logic [7:0]  down_seg_q, down_seg_d;     // downstream_segment_number
  logic [7:0]  high_seg_q, high_seg_d;     // highest_segment_behind
  logic        io_wide_q, io_wide_d;       // io_width_capability
  logic [3:0]  io_base_q, io_base_d;       // Window base, bits 15:12
  logic [3:0]  io_limit_q, io_limit_d;     // Window limit, bits 15:12
  logic        lock_q, lock_d;             // Locks the width capability bit

  // Write commit signals and the composed read byte
  logic        commit;                     // Address and data both present
  logic [11:0] wr_addr;                    // Address of the commit
  logic [31:0] wr_data;                    // Data of the commit
  logic [3:0]  wr_strb;                    // Strobes of the commit
  logic [7:0]  rd_byte_lo;                 // Low byte of a read, composed

  // --------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------

  // Channel readiness follows what is already held
  always_comb begin
    s_axi_awready = (wr_state_q == WR_IDLE) || (wr_state_q == WR_HAVE_DATA);
    s_axi_wready  = (wr_state_q == WR_IDLE) || (wr_state_q == WR_HAVE_ADDR);
  end

  // Pick address and data from the channel or from the holding flops
  always_comb begin
    wr_addr = (wr_state_q == WR_HAVE_ADDR) ? awaddr_q : s_axi_awaddr;
    wr_data = (wr_state_q == WR_HAVE_DATA) ? wdata_q : s_axi_wdata;
    wr_strb = (wr_state_q == WR_HAVE_DATA) ? wstrb_q : s_axi_wstrb;
    commit  = ((wr_state_q == WR_IDLE) && s_axi_awvalid && s_axi_wvalid) ||
              ((wr_state_q == WR_HAVE_ADDR) && s_axi_wvalid) ||
              ((wr_state_q == WR_HAVE_DATA) && s_axi_awvalid);
  end

  // Next state of the write channel
  always_comb begin
    wr_state_d = wr_state_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bresp_d    = bresp_q;
    case (wr_state_q)
      WR_IDLE: begin
        // Either half may arrive first
        if (s_axi_awvalid && !s_axi_wvalid) begin
          awaddr_d   = s_axi_awaddr;
          wr_state_d = WR_HAVE_ADDR;
        end else if (s_axi_wvalid && !s_axi_awvalid) begin
          wdata_d    = s_axi_wdata;
          wstrb_d    = s_axi_wstrb;
          wr_state_d = WR_HAVE_DATA;
        end
      end
      WR_HAVE_ADDR, WR_HAVE_DATA: begin
        // Wait for the missing half
      end
      WR_RESP: begin
        // Hold the response until the master takes it
        if (s_axi_bready) begin
          wr_state_d = WR_IDLE;
        end
      end
      default: begin
        wr_state_d = WR_IDLE;
      end
    endcase
    if (commit) begin
      bresp_d    = addr_known(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      wr_state_d = WR_RESP;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------

  // Only byte lane 0 carries a field; read-only words drop the write
  always_comb begin
    up_seg_d   = up_seg_q;
    down_seg_d = down_seg_q;
    high_seg_d = high_seg_q;
    io_wide_d  = io_wide_q;
    io_base_d  = io_base_q;
    io_limit_d = io_limit_q;
    lock_d     = lock_q;
    if (commit && wr_strb[0]) begin
      if (wr_addr == byte_addr(`IDX_UPSTREAM_SEGMENT_NUMBER)) begin
        up_seg_d = wr_data[7:0];
      end else if (wr_addr == byte_addr(`IDX_DOWNSTREAM_SEGMENT_NUMBER)) begin
        down_seg_d = wr_data[7:0];
      end else if (wr_addr == byte_addr(`IDX_HIGHEST_SEGMENT_BEHIND)) begin
        high_seg_d = wr_data[7:0];
      end else if (wr_addr == byte_addr(`IDX_IO_WINDOW_LOWER)) begin
        // Width bit takes writes only while unlocked
        if (!lock_q) begin
          io_wide_d = wr_data[`IO_WIDTH_BIT];
        end
        io_base_d = wr_data[`IO_ADDR_MSB:`IO_ADDR_LSB];
      end else if (wr_addr == byte_addr(`IDX_IO_WINDOW_UPPER)) begin
        // Bit 0 here is a mirror, so only the limit field is taken
        io_limit_d = wr_data[`IO_ADDR_MSB:`IO_ADDR_LSB];
      end else if (wr_addr == byte_addr(`IDX_HEADER_LOCK_CONTROL)) begin
        lock_d = wr_data[`LOCK_BIT];
      end
      // Header type, self test, base address words and latency count
      // have no storage, so writes to them vanish
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------

  // Address is taken whenever no read data is waiting
  always_comb begin
    s_axi_arready = (rd_state_q == RD_IDLE);
  end

  // Low byte of each read word
  always_comb begin
    rd_byte_lo = 8'h00;
    if (s_axi_araddr == byte_addr(`IDX_HEADER_LAYOUT_CODE)) begin
      rd_byte_lo = `HEADER_LAYOUT_VALUE;
    end else if (s_axi_araddr == byte_addr(`IDX_SELF_TEST_CONTROL)) begin
      rd_byte_lo = `SELF_TEST_VALUE;
    end else if (s_axi_araddr == byte_addr(`IDX_UPSTREAM_SEGMENT_NUMBER)) begin
      rd_byte_lo = up_seg_q;
    end else if (s_axi_araddr == byte_addr(`IDX_DOWNSTREAM_SEGMENT_NUMBER)) begin
      rd_byte_lo = down_seg_q;
    end else if (s_axi_araddr == byte_addr(`IDX_HIGHEST_SEGMENT_BEHIND)) begin
      rd_byte_lo = high_seg_q;
    end else if (s_axi_araddr == byte_addr(`IDX_DOWNSTREAM_LATENCY_COUNT)) begin
      rd_byte_lo = `LATENCY_COUNT_VALUE;
    end else if (s_axi_araddr == byte_addr(`IDX_IO_WINDOW_LOWER)) begin
      // Bits 3:1 stay zero
      rd_byte_lo = {io_base_q, 3'b000, io_wide_q};
    end else if (s_axi_araddr == byte_addr(`IDX_IO_WINDOW_UPPER)) begin
      // Bit 0 mirrors the width bit of the lower register
      rd_byte_lo = {io_limit_q, 3'b000, io_wide_q};
    end else if (s_axi_araddr == byte_addr(`IDX_HEADER_LOCK_CONTROL)) begin
      rd_byte_lo = {7'h00, lock_q};
    end
  end

  // Next state of the read channel
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    case (rd_state_q)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          // Base address words fall through to zero
          rdata_d    = {24'h00_0000, rd_byte_lo};
          rresp_d    = addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
          rd_state_d = RD_RESP;
        end
      end
      RD_RESP: begin
        // Hold data until the master takes it
        if (s_axi_rready) begin
          rd_state_d = RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Flops
  // --------------------------------------------------------------------

  // Bus channel state
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state_q <= WR_IDLE;
      rd_state_q <= RD_IDLE;
      awaddr_q   <= 12'h000;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bresp_q    <= `RESP_OKAY;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bresp_q    <= bresp_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  // Header fields
  always_ff @(posedge clk) begin
    if (rst) begin
      up_seg_q   <= `SEGMENT_RESET;
      down_seg_q <= `SEGMENT_RESET;
      high_seg_q <= `SEGMENT_RESET;
      io_wide_q  <= `IO_WIDTH_RESET;
      io_base_q  <= `IO_BASE_RESET;
      io_limit_q <= `IO_LIMIT_RESET;
      lock_q     <= `LOCK_RESET;
    end else begin
      up_seg_q   <= up_seg_d;
      down_seg_q <= down_seg_d;
      high_seg_q <= high_seg_d;
      io_wide_q  <= io_wide_d;
      io_base_q  <= io_base_d;
      io_limit_q <= io_limit_d;
      lock_q     <= lock_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  // Bus answers come straight from flops
  always_comb begin
    s_axi_bvalid = (wr_state_q == WR_RESP);
    s_axi_bresp  = bresp_q;
    s_axi_rvalid = (rd_state_q == RD_RESP);
    s_axi_rdata  = rdata_q;
    s_axi_rresp  = rresp_q;
  end

  // Window settings as seen by the forwarding logic
  always_comb begin
    io_window_q.wide  = io_wide_q;
    io_window_q.base  = io_base_q;
    io_window_q.limit = io_limit_q;
  end

  // --------------------------------------------------------------------
  // I/O forwarding decision
  // --------------------------------------------------------------------

  // Reset values put base above limit, so nothing forwards at first unless io_upper_limit is above io_upper_base
  io_window_match u_match (
    .clk         (clk),
    .rst         (rst),
    .win         (io_window_q),
    .upper_base  (io_upper_base),
    .upper_limit (io_upper_limit),
    .req         (io_req),
    .judged_q    (io_judged_q),
    .forward_q   (io_forward_q)
  );

endmodule : bridge_hdr_regs

// ### bridge_hdr_regs_assertions.sv
/* Checker for the bridge header bank: read answers, window fields, I/O verdict.
   Assumes: bound to bridge_hdr_regs by the bind at the foot of this file. */
`timescale 1ns/1ps
`include "bridge_hdr_defs.svh"
module bridge_hdr_checker (
  // Clock, reset and read channel
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [11:0]                s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  // I/O verdict and window
  input wire bridge_hdr_pkg::io_req_s    io_req,
  input wire logic                       io_judged_q,
  input wire logic                       io_forward_q,
  input wire bridge_hdr_pkg::io_window_s io_window_q
);
  import bridge_hdr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ar_take;    // Read address taken
  logic zero_word;  // Address of a word that reads zero
  logic narrow_hit; // Narrow-mode window match
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign zero_word = s_axi_araddr inside {12'h03C, 12'h040, 12'h050, 12'h06C};
  assign narrow_hit = io_req.addr[31:16] == 16'h0000 && io_req.addr[15:12] >= io_window_q.base
                      && io_req.addr[15:12] <= io_window_q.limit;
  // Read of one given address
  sequence ar_hit(logic [11:0] a);
    ar_take && s_axi_araddr == a;
  endsequence
  a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_header_code: assert property (
    ar_hit(12'h038) |=> s_axi_rdata == 32'h0000_0001) else $error("header code wrong");
  a_zero_words: assert property (
    ar_take && zero_word |=> s_axi_rdata == 32'h0 && s_axi_rresp == `RESP_OKAY)
    else $error("zero word wrong");
  a_lower_fields: assert property (
    ar_hit(12'h070) |=> s_axi_rdata == {24'h0, $past(io_window_q.base), 3'h0,
    $past(io_window_q.wide)}) else $error("window lower wrong");
  a_upper_mirror: assert property (
    ar_hit(12'h074) |=> s_axi_rdata == {24'h0, $past(io_window_q.limit), 3'h0,
    $past(io_window_q.wide)}) else $error("window upper wrong");
  a_window_reset: assert property (
    $past(rst) |-> io_window_q == 9'h1F0) else $error("window reset wrong");
  a_judge_pulse: assert property (
    io_req.valid |=> io_judged_q) else $error("verdict missing");
  a_idle_quiet: assert property (
    !io_req.valid |=> !io_judged_q && !io_forward_q) else $error("verdict unasked");
  a_narrow_verdict: assert property (
    io_req.valid && !io_window_q.wide |=> io_forward_q == $past(narrow_hit))
    else $error("verdict wrong");
endmodule : bridge_hdr_checker
bind bridge_hdr_regs bridge_hdr_checker chk_i (.clk(clk), .rst(rst),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .io_req(io_req), .io_judged_q(io_judged_q),
  .io_forward_q(io_forward_q), .io_window_q(io_window_q));

// ### bridge_hdr_regs_tb_top.sv
/* Testbench for the bridge header bank: register map, window, I/O verdict.
   Assumes: the checker file is compiled alongside. */
`timescale 1ns/1ps
`include "bridge_hdr_defs.svh"
module bridge_hdr_regs_tb_top;
  import bridge_hdr_pkg::*;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [2:0]  prot = '0;
  logic [3:0]  strb = 4'hF;
  logic [15:0] up_base = '0, up_limit = '0;
  io_req_s     io_req = '0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, judged, fwd;
  io_window_s  win;
  int          n_mismatch = 0, n_tests = 0;
  always #5 clk = ~clk;
  bridge_hdr_regs uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .io_upper_base(up_base), .io_upper_limit(up_limit),
    .io_req(io_req), .io_judged_q(judged), .io_forward_q(fwd), .io_window_q(win));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Write one word, halves released as taken, response checked
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    tb = 0;
    for (int n = 0; n < 20 && !tb; n++) begin
      @(negedge clk);
      ta = awv && awready;
      tw = wv && wready;
      tb = bvalid;
      if (tb) chk("bresp", bresp, er);
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) bready <= 0;
    end
    if (!tb) chk("bvalid", 0, 1);
  endtask : wr
  // Read one word and compare data and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ta, tr;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    tr = 0;
    for (int n = 0; n < 20 && !tr; n++) begin
      @(negedge clk);
      ta = arv && arready;
      tr = rvalid;
      if (tr) chk("rdata", rdata, ed);
      if (tr) chk("rresp", rresp, er);
      @(posedge clk);
      if (ta) arv <= 0;
      if (tr) rready <= 0;
    end
    if (!tr) chk("rvalid", 0, 1);
  endtask : rdc
  // One I/O request, verdict one cycle later
  task automatic io(input logic [31:0] a, input logic f);
    @(posedge clk);
    io_req <= '{valid: 1'b1, addr: a};
    @(posedge clk);
    io_req <= '0;
    @(negedge clk);
    chk("judged", judged, 1);
    chk("forward", fwd, f);
  endtask : io
  task automatic t_ro;
    logic [11:0] a [5] = '{12'h038, 12'h03C, 12'h040, 12'h050, 12'h06C};
    foreach (a[i]) begin
      wr(a[i], 32'hFFFF_FFFF, `RESP_OKAY);
      rdc(a[i], (i == 0) ? 32'h1 : 32'h0, `RESP_OKAY);
    end
    wr(12'h0FC, 32'h1, `RESP_SLVERR);
    rdc(12'h0FC, 32'h0, `RESP_SLVERR);
  endtask : t_ro
  task automatic t_rw;
    logic [11:0] a [3] = '{12'h060, 12'h064, 12'h068};
    foreach (a[i]) rdc(a[i], 32'h0, `RESP_OKAY);
    foreach (a[i]) wr(a[i], {24'hFFFFFF, 8'hA5 ^ i[7:0]}, `RESP_OKAY);
    strb <= 4'hE;
    wr(a[0], 32'h0000_0011, `RESP_OKAY);
    strb <= 4'hF;
    foreach (a[i]) rdc(a[i], {24'h0, 8'hA5 ^ i[7:0]}, `RESP_OKAY);
  endtask : t_rw
  task automatic t_win;
    @(negedge clk);
    chk("window", win, 9'h1F0);
    rdc(12'h070, 32'h0000_00F1, `RESP_OKAY);
    rdc(12'h074, 32'h0000_0001, `RESP_OKAY);
    io(32'h0000_F000, 0);
    wr(12'h070, 32'hFFFF_FF2E, `RESP_OKAY);
    wr(12'h074, 32'hFFFF_FF5F, `RESP_OKAY);
    rdc(12'h070, 32'h0000_0020, `RESP_OKAY);
    rdc(12'h074, 32'h0000_0050, `RESP_OKAY);
    @(negedge clk);
    chk("window", win, 9'h025);
  endtask : t_win
  task automatic t_fwd;
    logic [32:0] t [5] = '{{1'b0, 32'h1FFF}, {1'b1, 32'h2000}, {1'b1, 32'h5FFF},
                          {1'b0, 32'h6000}, {1'b0, 32'h1_3000}};
    foreach (t[i]) io(t[i][31:0], t[i][32]);
    @(posedge clk);
    up_base <= 16'h0001;
    up_limit <= 16'h0001;
    wr(12'h070, 32'h0000_0021, `RESP_OKAY);
    io(32'h0001_3000, 1);
    io(32'h0000_3000, 0);
    // Locked width bit keeps wide while the base field still moves
    wr(12'h100, 32'h0000_0001, `RESP_OKAY);
    rdc(12'h100, 32'h0000_0001, `RESP_OKAY);
    wr(12'h070, 32'h0000_0030, `RESP_OKAY);
    rdc(12'h070, 32'h0000_0031, `RESP_OKAY);
    rdc(12'h074, 32'h0000_0051, `RESP_OKAY);
  endtask : t_fwd
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_ro;
    t_rw;
    t_win;
    t_fwd;
    results;
  end
  // Watchdog well beyond the 120-odd cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
endmodule : bridge_hdr_regs_tb_top

// ### io_window_match.sv
/*
  I/O forwarding window decoder: judges whether a primary-side I/O
  address falls inside the programmed base..limit range.
  Assumes: window settings come from the register bank; upper address
  halves for wide addressing come from registers outside this block.
*/
`timescale 1ns/1ps
`include "bridge_hdr_defs.svh"

module io_window_match (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Window settings
  input  wire bridge_hdr_pkg::io_window_s win,
  input  wire logic [15:0]               upper_base,
  input  wire logic [15:0]               upper_limit,
  // Request and verdict
  input  wire bridge_hdr_pkg::io_req_s   req,
  output logic                           judged_q,
  output logic                           forward_q
);
  import bridge_hdr_pkg::*;

  logic [31:0] low_addr;   // Bottom of the window
  logic [31:0] high_addr;  // Top of the window
  logic        judged_d;   // Next verdict strobe
  logic        forward_d;  // Next verdict

  // Build the window edges; narrow mode keeps the upper half at zero
  always_comb begin
    low_addr  = {(win.wide ? upper_base  : 16'h0000), win.base,  `IO_LOW_FILL};
    high_addr = {(win.wide ? upper_limit : 16'h0000), win.limit, `IO_HIGH_FILL};
    judged_d  = req.valid;
    // Inclusive compare; low_addr above high_addr leaves the window empty
    forward_d = req.valid && (req.addr >= low_addr) && (req.addr <= high_addr);
  end

  // Register the verdict
  always_ff @(posedge clk) begin
    if (rst) begin
      judged_q  <= 1'b0;
      forward_q <= 1'b0;
    end else begin
      judged_q  <= judged_d;
      forward_q <= forward_d;
    end
  end

endmodule : io_window_match
